// ==== pkg/spdc_pkg.sv ====
// Package for the sleep power domain controller: register map, field
// positions, reset values and the power mode enumeration.
// Assumes a 32-bit APB register bus with byte addresses.
package spdc_pkg;

  // Register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_OTP_WORDS = 12'h008;
  localparam logic [11:0] OFS_RADIO_RET = 12'h00C;
  localparam logic [11:0] OFS_GEN_CTRL = 12'h010;

  // Control register fields
  localparam int CTRL_RETAIN_SYSRAM = 0;
  localparam int CTRL_PER_EN = 1;
  localparam int CTRL_RAD_EN = 2;
  localparam int CTRL_RR_LSB = 3;
  localparam int NUM_RR = 4;
  localparam int CTRL_W = CTRL_RR_LSB + NUM_RR;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h06;

  // Status register fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_MODE_W = 3;
  localparam int STAT_COLD = 3;
  localparam int STAT_MIRROR = 4;
  localparam int STAT_SYSRAM_ACC = 5;

  // Retained radio register: control fields low, freeze enable above
  localparam int RADIO_DBG_FREEZE = 16;

  // Processor system control word: deep sleep request bit
  localparam int SCR_W = 4;
  localparam int SCR_DEEP_BIT = 2;

  // Retention RAM sizes in kB, one per switched domain, and system RAM
  localparam int RR_KB [NUM_RR] = '{2, 3, 2, 1};
  localparam int SYSRAM_KB = 42;

  // Analog enables switched off in extended and deep sleep
  localparam int AN_BANDGAP = 0;
  localparam int AN_DCDC = 1;
  localparam int AN_XTAL16 = 2;
  localparam int AN_RC_OSC = 3;
  localparam int AN_ADC = 4;
  localparam int AN_LDO = 5;
  localparam int AN_W = 6;

  // Wake pin filter depth
  localparam int SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    MODE_POWER_UP,
    MODE_MIRROR,
    MODE_ACTIVE,
    MODE_SLEEP,
    MODE_EXT_SLEEP,
    MODE_DEEP_SLEEP
  } spdc_mode_e;

endpackage

// ==== rtl/spdc_ctrl.sv ====
// Sleep power domain controller: power mode state machine, domain switch
// outputs, analog enables and the always-on retained registers.
// Assumes the core, wake logic and sequencers share clk_in; the wake pin
// is asynchronous. Registers are reached over APB with 32-bit data.
`timescale 1ns/1ps

// Summary of operation
// R1 - Extended sleep keeps always-on, retention RAMs, sysram
// R2 - Deep sleep keeps always-on and retention RAMs
// R3 - Extended sleep wake skips OTP mirror
// R4 - Deep sleep wake mirrors OTP again
// R5 - Retain bit plus deep request: extended sleep
// R6 - Deep request alone selects deep sleep
// R7 - Software gates peripheral, radio, retention RAMs
// R8 - Extended and deep sleep entry switch system and debug off
// R9 - Extended and deep sleep entry switch analog blocks off
// R10 - Plain sleep applies no power gating
// R11 - Always-on domain powered in every mode
// R12 - System domain on only while core is powered
// R13 - Software can switch peripheral domain off
// R14 - Four switched retention RAMs, unused ones off
// R15 - Sysram keeps contents but is inaccessible
// R16 - Radio control and freeze fields retained
// R17 - OTP word count survives all sleep modes
// R18 - Always-on registers keep values through sleep
// R19 - Peripheral registers lost when domain off
// R20 - Power-up sequence on cold start and on wake from extended or deep sleep
// R21 - Sleep takes effect only on core sleep
module spdc_ctrl
  import spdc_pkg::*;
#(
  parameter int OTP_W = 16,
  parameter int RADIO_W = 16,
  parameter int EM_W = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic core_sleeping_in,
  input wire logic [SCR_W-1:0] core_sys_ctrl_in,
  input wire logic wake_pin_in,
  input wire logic wake_event_in,
  output logic pwr_seq_start_out,
  input wire logic pwr_seq_done_in,
  output logic otp_mirror_start_out,
  input wire logic otp_mirror_done_in,
  output logic always_on_domain_on_out,
  output logic system_domain_on_out,
  output logic debug_domain_on_out,
  output logic peripheral_domain_on_out,
  output logic peripheral_domain_rst_out,
  output logic radio_domain_on_out,
  output logic [NUM_RR-1:0] retention_ram_domains_on_out,
  output logic sysram_domain_on_out,
  output logic sysram_access_out,
  output logic [AN_W-1:0] analog_en_out,
  output logic cold_start_out,
  output logic [OTP_W-1:0] otp_word_count_out,
  output logic [RADIO_W-1:0] radio_control2_out,
  output logic debug_freeze_enable_out,
  output logic [EM_W-1:0] exchange_memory_map_field_out
);

  typedef struct packed {
    spdc_mode_e mode;
    logic cold_start;
    logic mirror_needed;
    logic seq_issued;
    logic wake_prev;
    logic [CTRL_W-1:0] ctrl;
    logic [OTP_W-1:0] otp_words;
    logic [RADIO_W-1:0] radio_ret;
    logic dbg_freeze;
    logic [EM_W-1:0] exchange_memory_map_field;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic seq_start;
    logic mirror_start;
    logic aon_on;
    logic sys_on;
    logic dbg_on;
    logic per_on;
    logic per_rst;
    logic rad_on;
    logic [NUM_RR-1:0] rr_on;
    logic sysram_on;
    logic sysram_acc;
    logic [AN_W-1:0] analog_en;
  } spdc_state_s;

  spdc_state_s r;
  spdc_state_s next_r;
  logic wake_pin_level;

  // Wake pin arrives from a pad, so it is filtered before use
  spdc_sync #(
    .WIDTH(1)
  ) u_wake_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(wake_pin_in),
    .level_out(wake_pin_level)
  );

  // Byte-lane merge of an APB write into a 32-bit register image
  function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic apb_setup;
  logic apb_access;
  logic addr_hit;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic deep_req;
  logic wake;
  logic core_powered;

  always_comb begin
    apb_setup = psel_in && !penable_in;
    apb_access = psel_in && penable_in && r.pready;
    addr_hit = 1'b0;
    rd_val = 32'h0000_0000;
    wr_val = 32'h0000_0000;
    deep_req = core_sys_ctrl_in[SCR_DEEP_BIT];
    wake = wake_event_in || (wake_pin_level && !r.wake_prev);
    core_powered = 1'b1;

    next_r = r;
    next_r.seq_start = 1'b0;
    next_r.mirror_start = 1'b0;
    next_r.wake_prev = wake_pin_level;

    // Register read image and decode
    unique case (paddr_in)
      OFS_CTRL: begin
        addr_hit = 1'b1;
        rd_val = 32'(r.ctrl);
      end
      OFS_STATUS: begin
        addr_hit = 1'b1;
        rd_val[STAT_MODE_LSB +: STAT_MODE_W] = STAT_MODE_W'(r.mode);
        rd_val[STAT_COLD] = r.cold_start;
        rd_val[STAT_MIRROR] = r.mirror_needed;
        rd_val[STAT_SYSRAM_ACC] = r.sysram_acc;
      end
      OFS_OTP_WORDS: begin
        addr_hit = 1'b1;
        rd_val = 32'(r.otp_words);
      end
      OFS_RADIO_RET: begin
        addr_hit = 1'b1;
        rd_val = 32'(r.radio_ret);
        rd_val[RADIO_DBG_FREEZE] = r.dbg_freeze;
      end
      OFS_GEN_CTRL: begin
        addr_hit = 1'b1;
        rd_val = 32'(r.exchange_memory_map_field);
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase

    // APB slave: answer in the first access cycle, no wait states
    if (apb_setup) begin
      next_r.pready = 1'b1;
      next_r.pslverr = !addr_hit;
      next_r.prdata = (pwrite_in || !addr_hit) ? 32'h0000_0000 : rd_val;
    end else if (apb_access) begin
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
      next_r.prdata = 32'h0000_0000;
      if (pwrite_in && addr_hit) begin
        wr_val = merge_strb(rd_val, pwdata_in, pstrb_in);
        unique case (paddr_in)
          OFS_CTRL: begin
            // Peripheral, radio and retention RAM switches are software's job
            next_r.ctrl = wr_val[CTRL_W-1:0]; // see R7 see R13 see R14
          end
          OFS_OTP_WORDS: begin
            next_r.otp_words = wr_val[OTP_W-1:0]; // see R17
          end
          OFS_RADIO_RET: begin
            next_r.radio_ret = wr_val[RADIO_W-1:0]; // see R16
            next_r.dbg_freeze = wr_val[RADIO_DBG_FREEZE]; // see R16
          end
          OFS_GEN_CTRL: begin
            next_r.exchange_memory_map_field = wr_val[EM_W-1:0]; // see R18
          end
          default: begin
            // Status is read only; writes are dropped without error
            next_r.ctrl = r.ctrl;
          end
        endcase
      end
    end else begin
      next_r.pready = 1'b0;
      next_r.pslverr = 1'b0;
    end

    // Power mode state machine
    unique case (r.mode)
      MODE_POWER_UP: begin
        if (!r.seq_issued) begin
          next_r.seq_start = 1'b1; // see R20
          next_r.seq_issued = 1'b1;
        end else if (pwr_seq_done_in) begin
          next_r.seq_issued = 1'b0;
          if (r.cold_start) begin
            // Boot code mirrors OTP on a cold start, not the hardware
            next_r.cold_start = 1'b0; // see R20
            next_r.mirror_needed = 1'b0;
            next_r.mode = MODE_ACTIVE;
          end else if (r.mirror_needed) begin
            next_r.mode = MODE_MIRROR; // see R4
          end else begin
            next_r.mode = MODE_ACTIVE; // see R3
          end
        end
      end
      MODE_MIRROR: begin
        if (!r.seq_issued) begin
          next_r.mirror_start = 1'b1; // see R4
          next_r.seq_issued = 1'b1;
        end else if (otp_mirror_done_in) begin
          next_r.seq_issued = 1'b0;
          next_r.mirror_needed = 1'b0;
          next_r.mode = MODE_ACTIVE;
        end
      end
      MODE_ACTIVE: begin
        // Nothing changes until the core really stops
        if (core_sleeping_in) begin // see R21
          if (!deep_req) begin
            next_r.mode = MODE_SLEEP; // see R10
          end else if (r.ctrl[CTRL_RETAIN_SYSRAM]) begin
            next_r.mode = MODE_EXT_SLEEP; // see R5
            next_r.mirror_needed = 1'b0;
          end else begin
            next_r.mode = MODE_DEEP_SLEEP; // see R6
            next_r.mirror_needed = 1'b1;
          end
        end
      end
      MODE_SLEEP: begin
        // The core leaves plain sleep on its own interrupt
        if (!core_sleeping_in) begin
          next_r.mode = MODE_ACTIVE; // see R10
        end
      end
      MODE_EXT_SLEEP, MODE_DEEP_SLEEP: begin
        if (wake) begin
          next_r.mode = MODE_POWER_UP; // see R20
          next_r.seq_issued = 1'b0;
        end
      end
      default: begin
        next_r.mode = MODE_POWER_UP;
        next_r.seq_issued = 1'b0;
      end
    endcase

    // System, debug, sysram and analog switches follow the mode being entered, so they change with it
    core_powered = !(next_r.mode == MODE_EXT_SLEEP || next_r.mode == MODE_DEEP_SLEEP);
    next_r.aon_on = 1'b1; // see R11 see R18
    next_r.sys_on = core_powered; // see R8 see R12
    next_r.dbg_on = core_powered; // see R8
    next_r.sysram_acc = core_powered; // see R15
    next_r.sysram_on = (next_r.mode != MODE_DEEP_SLEEP); // see R1 see R2 see R8
    next_r.analog_en = core_powered ? {AN_W{1'b1}} : {AN_W{1'b0}}; // see R9
    next_r.per_on = r.ctrl[CTRL_PER_EN]; // see R13
    next_r.per_rst = !r.ctrl[CTRL_PER_EN]; // see R19
    next_r.rad_on = r.ctrl[CTRL_RAD_EN]; // see R1 see R2
    next_r.rr_on = r.ctrl[CTRL_RR_LSB +: NUM_RR]; // see R14
  end

  // Sleep never resets these registers; only rst_in does
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r.mode <= MODE_POWER_UP;
      r.cold_start <= 1'b1; // see R20
      r.mirror_needed <= 1'b0;
      r.seq_issued <= 1'b0;
      r.wake_prev <= 1'b0;
      r.ctrl <= CTRL_RESET;
      r.otp_words <= '0;
      r.radio_ret <= '0;
      r.dbg_freeze <= 1'b0;
      r.exchange_memory_map_field <= '0;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= 32'h0000_0000;
      r.seq_start <= 1'b0;
      r.mirror_start <= 1'b0;
      r.aon_on <= 1'b1;
      r.sys_on <= 1'b1;
      r.dbg_on <= 1'b1;
      r.per_on <= CTRL_RESET[CTRL_PER_EN];
      r.per_rst <= !CTRL_RESET[CTRL_PER_EN];
      r.rad_on <= CTRL_RESET[CTRL_RAD_EN];
      r.rr_on <= CTRL_RESET[CTRL_RR_LSB +: NUM_RR];
      r.sysram_on <= 1'b1;
      r.sysram_acc <= 1'b1;
      r.analog_en <= {AN_W{1'b1}};
    end else begin
      r <= next_r;
    end
  end

  assign prdata_out = r.prdata;
  assign pready_out = r.pready;
  assign pslverr_out = r.pslverr;
  assign pwr_seq_start_out = r.seq_start;
  assign otp_mirror_start_out = r.mirror_start;
  assign always_on_domain_on_out = r.aon_on;
  assign system_domain_on_out = r.sys_on;
  assign debug_domain_on_out = r.dbg_on;
  assign peripheral_domain_on_out = r.per_on;
  assign peripheral_domain_rst_out = r.per_rst;
  assign radio_domain_on_out = r.rad_on;
  assign retention_ram_domains_on_out = r.rr_on;
  assign sysram_domain_on_out = r.sysram_on;
  assign sysram_access_out = r.sysram_acc;
  assign analog_en_out = r.analog_en;
  assign cold_start_out = r.cold_start;
  assign otp_word_count_out = r.otp_words;
  assign radio_control2_out = r.radio_ret;
  assign debug_freeze_enable_out = r.dbg_freeze;
  assign exchange_memory_map_field_out = r.exchange_memory_map_field;

endmodule

// ==== rtl/spdc_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the input may change at any time relative to clk_in.
`timescale 1ns/1ps
module spdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } spdc_sync_s;

  spdc_sync_s r;
  spdc_sync_s next_r;

  // The first stage feeds only the second; the filter looks at stages 2 and 3
  always_comb begin
    next_r = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.level[i] = r.s2[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level_out = r.level;

endmodule

// ==== tb/spdc_core_model.sv ====
// Core and software side: sleep requests, plus the power-up and mirror
// sequencers answering each start pulse after a chosen delay.
// Assumes the controller clock; the bench sets requests and delay.
`timescale 1ns/1ps
module spdc_core_model
  import spdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sleep_req_in,
  input wire logic deep_req_in,
  input wire logic [3:0] delay_in,
  input wire logic pwr_seq_start_in,
  input wire logic otp_mirror_start_in,
  output logic core_sleeping_out,
  output logic [SCR_W-1:0] core_sys_ctrl_out,
  output logic pwr_seq_done_out,
  output logic otp_mirror_done_out
);
  logic busy;
  logic is_mirror;
  logic [3:0] left;
  always_ff @(posedge clk_in) begin
    pwr_seq_done_out <= 1'b0;
    otp_mirror_done_out <= 1'b0;
    if (rst_in) begin
      core_sleeping_out <= 1'b0;
      core_sys_ctrl_out <= '0;
      busy <= 1'b0;
    end else begin
      core_sys_ctrl_out <= SCR_W'(deep_req_in) << SCR_DEEP_BIT;
      core_sleeping_out <= sleep_req_in;
      if (pwr_seq_start_in || otp_mirror_start_in) begin
        busy <= 1'b1;
        is_mirror <= otp_mirror_start_in;
        left <= delay_in;
      end else if (busy && left == 4'h0) begin
        busy <= 1'b0;
        pwr_seq_done_out <= !is_mirror;
        otp_mirror_done_out <= is_mirror;
      end else if (busy) begin
        left <= left - 4'h1;
      end
    end
  end
endmodule

// ==== tb/spdc_ctrl_bench.sv ====
// Self-checking bench for spdc_ctrl: APB master, core model, mode tours.
// Assumes the package register map and default parameter widths.
`timescale 1ns/1ps
module spdc_ctrl_bench;
  import spdc_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwd = '0, prd, v, q, seed = 32'h35912414;
  logic prdy, perr, slp, sqs, sqd, mrs, mrd, aon, sys, dbg, per, prst, rad, sr, acc, cold, frz, e;
  logic wpin = 1'b0, wev = 1'b0, sreq = 1'b0, dreq = 1'b0;
  logic [3:0] scr, rr, dly = 4'h3;
  logic [5:0] an;
  logic [15:0] otw, r2;
  logic [1:0] em;
  int miscompares = 0, total_checks = 0, mir_cnt = 0, seq_cnt = 0, i, j, m, n0, s0;
  logic [11:0] ofs [3] = '{OFS_OTP_WORDS, OFS_RADIO_RET, OFS_GEN_CTRL};
  logic [31:0] msk [3] = '{32'h0000FFFF, 32'h0001FFFF, 32'h00000003};
  logic [31:0] shadow [3];
  always #5 clk_in = ~clk_in;
  spdc_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .pstrb_in(4'hF), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .core_sleeping_in(slp), .core_sys_ctrl_in(scr),
    .wake_pin_in(wpin), .wake_event_in(wev), .pwr_seq_start_out(sqs), .pwr_seq_done_in(sqd),
    .otp_mirror_start_out(mrs), .otp_mirror_done_in(mrd), .always_on_domain_on_out(aon),
    .system_domain_on_out(sys), .debug_domain_on_out(dbg), .peripheral_domain_on_out(per),
    .peripheral_domain_rst_out(prst), .radio_domain_on_out(rad),
    .retention_ram_domains_on_out(rr), .sysram_domain_on_out(sr), .sysram_access_out(acc),
    .analog_en_out(an), .cold_start_out(cold), .otp_word_count_out(otw),
    .radio_control2_out(r2), .debug_freeze_enable_out(frz),
    .exchange_memory_map_field_out(em));
  spdc_core_model core (.clk_in(clk_in), .rst_in(rst_in), .sleep_req_in(sreq),
    .deep_req_in(dreq), .delay_in(dly), .pwr_seq_start_in(sqs), .otp_mirror_start_in(mrs),
    .core_sleeping_out(slp), .core_sys_ctrl_out(scr), .pwr_seq_done_out(sqd),
    .otp_mirror_done_out(mrd));
  always @(posedge clk_in) begin
    if (mrs === 1'b1) mir_cnt++;
    if (sqs === 1'b1) seq_cnt++;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Domains, sysram, access and analog enables expected in sleep mode m
  function automatic logic [31:0] exp_dom(input int m);
    logic on;
    on = (m == 0);
    return {22'h0, on, on, m != 2, on, {AN_W{on}}};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_in);
    if (n == 20) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
    chk(32'(e), 32'h0);
  endtask
  // Polls the mode field; the wait ends the run if the mode is not MODE_ACTIVE within 60 polls
  task automatic wait_active();
    int n;
    for (n = 0; n < 60; n++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (q[2:0] === MODE_ACTIVE) break;
    end
    if (n == 60) begin
      miscompares++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk(32'(cold), 32'h1);
    rd(OFS_CTRL, 32'hFFFFFFFF, 32'(CTRL_RESET));
    wait_active();
    chk({cold, 31'(seq_cnt)}, 32'h1);
    for (i = 0; i < 8; i++) begin
      j = i % 3;
      v = xs();
      apb(1'b1, ofs[j], v);
      shadow[j] = v & msk[j];
      rd(ofs[j], 32'hFFFFFFFF, shadow[j]);
    end
    apb(1'b1, 12'h014, xs());
    chk(32'(e), 32'h1);
    apb(1'b0, 12'h014, 32'h0);
    chk({e, q[30:0]}, 32'h80000000);
    apb(1'b1, OFS_STATUS, 32'hFFFFFFF8);
    chk(32'(e), 32'h0);
    rd(OFS_STATUS, 32'h7, 32'(MODE_ACTIVE));
    for (m = 0; m < 3; m++) begin
      dly <= 4'(xs());
      v = {25'h0, 4'(xs()), m == 0, m == 0, m == 1};
      apb(1'b1, OFS_CTRL, v);
      dreq <= (m != 0);
      repeat (3) @(posedge clk_in);
      chk(32'(sys), 32'h1);
      sreq <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk({22'h0, sys, dbg, sr, acc, an}, exp_dom(m));
      chk(32'({aon, per, prst, rad, rr}), 32'({1'b1, v[1], !v[1], v[2], v[6:3]}));
      rd(OFS_STATUS, 32'h3F, {26'h0, m == 0, m == 2, 1'b0, 3'(m + 3)});
      n0 = mir_cnt;
      s0 = seq_cnt;
      wev <= (m == 2);
      wpin <= (m == 1);
      sreq <= 1'b0;
      dreq <= 1'b0;
      @(posedge clk_in);
      wev <= 1'b0;
      repeat (6) @(posedge clk_in);
      wpin <= 1'b0;
      wait_active();
      chk(32'(mir_cnt - n0), 32'(m == 2));
      chk(32'(seq_cnt - s0), 32'(m != 0));
      chk(32'({sys, acc}), 32'h3);
      for (j = 0; j < 3; j++) rd(ofs[j], 32'hFFFFFFFF, shadow[j]);
      chk(32'(otw), shadow[0]);
      chk({15'h0, frz, r2}, shadow[1]);
      chk(32'(em), shadow[2]);
    end
    print_verdict();
  end
endmodule
bind spdc_ctrl spdc_ctrl_checker u_chk (.clk_in(clk_in), .rst_in(rst_in),
  .core_sleeping_in(core_sleeping_in), .core_sys_ctrl_in(core_sys_ctrl_in),
  .pwr_seq_start_out(pwr_seq_start_out), .otp_mirror_start_out(otp_mirror_start_out),
  .always_on_domain_on_out(always_on_domain_on_out),
  .system_domain_on_out(system_domain_on_out), .debug_domain_on_out(debug_domain_on_out),
  .sysram_domain_on_out(sysram_domain_on_out), .sysram_access_out(sysram_access_out),
  .analog_en_out(analog_en_out));

// ==== tb/spdc_ctrl_checker.sv ====
// Port checker for the sleep power domain controller.
// Assumes one clock domain; bound to spdc_ctrl from the bench top file.
`timescale 1ns/1ps
module spdc_ctrl_checker
  import spdc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic core_sleeping_in,
  input wire logic [SCR_W-1:0] core_sys_ctrl_in,
  input wire logic pwr_seq_start_out,
  input wire logic otp_mirror_start_out,
  input wire logic always_on_domain_on_out,
  input wire logic system_domain_on_out,
  input wire logic debug_domain_on_out,
  input wire logic sysram_domain_on_out,
  input wire logic sysram_access_out,
  input wire logic [AN_W-1:0] analog_en_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // A mirror is owed only once sysram has lost power
  logic deep_wake;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      deep_wake <= 1'b0;
    end else if ($fell(sysram_domain_on_out)) begin
      deep_wake <= 1'b1;
    end else if (otp_mirror_start_out) begin
      deep_wake <= 1'b0;
    end
  end
  sequence entry_s;
    $fell(system_domain_on_out);
  endsequence
  sequence wake_s;
    $rose(system_domain_on_out);
  endsequence
  chk_aon_stays_on: assert property (always_on_domain_on_out)
    else $error("always-on domain switched off");
  chk_sys_dbg_pair: assert property (system_domain_on_out == debug_domain_on_out)
    else $error("debug domain differs from system domain");
  chk_analog_follow: assert property (analog_en_out == {AN_W{system_domain_on_out}})
    else $error("analog enables wrong for mode");
  chk_sysram_access: assert property (sysram_access_out == system_domain_on_out)
    else $error("sysram access wrong");
  chk_sysram_deep: assert property (!sysram_domain_on_out |-> !system_domain_on_out)
    else $error("sysram off while system on");
  chk_entry_cause: assert property (entry_s |-> $past(core_sleeping_in)
    && $past(core_sys_ctrl_in[SCR_DEEP_BIT])) else $error("gating without deep sleep");
  chk_wake_seq: assert property (wake_s |=> pwr_seq_start_out)
    else $error("no power-up sequence on wake");
  chk_start_pulse: assert property ((pwr_seq_start_out || otp_mirror_start_out)
    |=> !(pwr_seq_start_out || otp_mirror_start_out)) else $error("start held too long");
  chk_mirror_deep: assert property (otp_mirror_start_out |-> deep_wake)
    else $error("mirror without deep sleep");
endmodule
